// *** acs_defs.vh ***
// acs_defs.vh: register map, field positions and reset values of the cell switch
// assumes: included by bare name from the cell switch design files
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

// ==========================================
// register indices (byte address = 4 * index)
`define ACS_IDX_THR0 11'h698
`define ACS_IDX_THR1 11'h69A
`define ACS_IDX_PASEL 11'h6A0
`define ACS_IDX_HECX 11'h6A2
`define ACS_IDX_URTE 11'h6A4
`define ACS_IDX_ORTE 11'h6A6
`define ACS_IDX_STAT 11'h6A8
`define ACS_IDX_W 11

// ==========================================
// apb
`define ACS_ADDR_W 13
`define ACS_DATA_W 32
`define ACS_ALIGN_LSB 2
`define ACS_ZERO32 32'h00000000

// ==========================================
// stored widths and reset values
`define ACS_THR0_W 14
`define ACS_THR0_RST 14'h3F3F
`define ACS_THR1_W 4
`define ACS_THR1_RST 4'h0
`define ACS_PASEL_W 5
`define ACS_PASEL_RST 5'h00
`define ACS_HECX_W 8
`define ACS_HECX_RST 8'h55
`define ACS_RTE_W 12
`define ACS_RTE_RST 12'h000
`define ACS_UADDR_RST 5'h00
`define ACS_HEC_TX_RST 8'h00

// ==========================================
// fields of thresholds_0
`define ACS_RX_LVL 5:0
`define ACS_A_LVL 9:6
`define ACS_B_LVL 13:10
`define ACS_RX_OFF 6'h3F
`define ACS_PORT_OFF 4'hF

// ==========================================
// source ports and destination bits
`define ACS_SRC_A 2'h0
`define ACS_SRC_B 2'h1
`define ACS_SRC_C 2'h2
`define ACS_DST_N 4
`define ACS_RTE_A 3:0
`define ACS_RTE_B 7:4
`define ACS_RTE_C 11:8

`endif

// *** acs_route.v ***
// acs_route.v: destination choice for cells that failed the header match
// assumes: one cell descriptor per valid cycle, masks stable from the register file
`default_nettype none
`include "acs_defs.vh"

module acs_route (
  input wire i_ref_clk, // system clock
  input wire i_reset, // synchronous reset, active high
  input wire i_cell_valid, // unmatched cell descriptor present
  input wire [1:0] i_cell_src, // source port: 0 A, 1 B, 2 C
  input wire i_cell_oam, // cell is an oam cell
  input wire [`ACS_RTE_W-1:0] i_user_route, // user cell masks
  input wire [`ACS_RTE_W-1:0] i_maint_route, // oam cell masks
  output reg [`ACS_DST_N-1:0] o_dest, // copy to: 0 A, 1 B, 2 C, 3 aal0
  output reg o_dest_valid, // one-cycle pulse with o_dest
  output reg o_discard // one-cycle pulse, cell dropped
);

  // ==========================================
  // mask selection
  reg [`ACS_DST_N-1:0] sel_mask;
  always @* begin
    sel_mask = {`ACS_DST_N{1'b0}};
    case (i_cell_src)
      `ACS_SRC_A: sel_mask = i_cell_oam ? i_maint_route[`ACS_RTE_A]
                                        : i_user_route[`ACS_RTE_A];
      `ACS_SRC_B: sel_mask = i_cell_oam ? i_maint_route[`ACS_RTE_B]
                                        : i_user_route[`ACS_RTE_B];
      `ACS_SRC_C: sel_mask = i_cell_oam ? i_maint_route[`ACS_RTE_C]
                                        : i_user_route[`ACS_RTE_C];
      default: sel_mask = {`ACS_DST_N{1'b0}};
    endcase
  end

  // ==========================================
  // one flop per destination; every set bit gets a copy
  genvar d;
  generate
    for (d = 0; d < `ACS_DST_N; d = d + 1) begin : g_dst
      always @(posedge i_ref_clk) begin
        if (i_reset) begin
          o_dest[d] <= 1'b0;
        end else begin
          o_dest[d] <= i_cell_valid & sel_mask[d];
        end
      end
    end
  endgenerate

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_dest_valid <= 1'b0;
      o_discard <= 1'b0;
    end else begin
      o_dest_valid <= i_cell_valid & (|sel_mask);
      o_discard <= i_cell_valid & ~(|sel_mask);
    end
  end

endmodule // acs_route
`default_nettype wire

// *** acs_switch.v ***
// acs_switch.v: cell switch configuration, transmit segmenter backpressure,
// port A multi-phy address response, header check masking, unmatched routing
// assumes: apb master on i_ref_clk; fifo fills and cell strobes from logic on
// the same clock; utopia clock and address arrive from pins
`default_nettype none
`include "acs_defs.vh"

module acs_switch (
  input wire i_ref_clk, // system clock, 40 MHz
  input wire i_reset, // synchronous reset, active high
  // apb slave
  input wire i_psel, // apb select
  input wire i_penable, // apb enable
  input wire i_pwrite, // apb direction, high = write
  input wire [`ACS_ADDR_W-1:0] i_paddr, // apb byte address
  input wire [`ACS_DATA_W-1:0] i_pwdata, // apb write data
  output reg o_pready, // apb ready
  output reg [`ACS_DATA_W-1:0] o_prdata, // apb read data
  output reg o_pslverr, // apb error, unmapped address
  // fifo fills
  input wire [5:0] i_rx_reasm_fill, // reassembly output fifo fill
  input wire [3:0] i_port_a_fill, // port A output fifo fill
  input wire [3:0] i_port_b_fill, // port B output fifo fill
  input wire [3:0] i_port_c_fill, // port C output fifo fill
  output reg o_tx_seg_block, // stop taking segmenter input cells
  // utopia level 2 port A
  input wire i_utopia_clk, // utopia clock pin
  input wire [4:0] i_utopia_addr, // polled or selected phy address pins
  output reg o_port_a_respond, // port A is the addressed phy
  // header check byte
  input wire i_hec_valid, // computed check byte present
  input wire [7:0] i_hec_calc, // computed check byte
  output reg o_hec_valid, // masked byte present, one-cycle pulse
  output reg [7:0] o_hec_tx, // masked check byte to transmit
  // unmatched cells
  input wire i_cell_valid, // unmatched cell descriptor, one cycle
  input wire [1:0] i_cell_src, // source port: 0 A, 1 B, 2 C
  input wire i_cell_oam, // cell is an oam cell
  output wire [`ACS_DST_N-1:0] o_cell_dest, // destination copies
  output wire o_cell_dest_valid, // pulse with o_cell_dest
  output wire o_cell_discard // pulse when dropped
);

  // ==========================================
  // configuration registers
  reg [`ACS_THR0_W-1:0] thr0;
  reg [`ACS_THR1_W-1:0] first_unused_thr1;
  reg [`ACS_PASEL_W-1:0] port_a_sel;
  reg [`ACS_HECX_W-1:0] hec_xor;
  reg [`ACS_RTE_W-1:0] user_route;
  reg [`ACS_RTE_W-1:0] maint_route;

  wire [5:0] rx_level;
  wire [3:0] first_port_fifo_block_level;
  wire [3:0] second_port_fifo_block_level;
  wire [3:0] third_port_fifo_block_level;

  assign rx_level = thr0[`ACS_RX_LVL];
  assign first_port_fifo_block_level = thr0[`ACS_A_LVL];
  assign second_port_fifo_block_level = thr0[`ACS_B_LVL];
  assign third_port_fifo_block_level = first_unused_thr1;

  // ==========================================
  // apb decode
  wire [`ACS_IDX_W-1:0] idx;
  wire aligned;
  wire hit_thr0;
  wire hit_thr1;
  wire hit_pasel;
  wire hit_hecx;
  wire hit_urte;
  wire hit_orte;
  wire hit_stat;
  wire mapped;
  wire acc_done;
  wire wr_done;

  assign idx = i_paddr[`ACS_ADDR_W-1:`ACS_ALIGN_LSB];
  assign aligned = (i_paddr[`ACS_ALIGN_LSB-1:0] == 2'h0);
  assign hit_thr0 = aligned & (idx == `ACS_IDX_THR0);
  assign hit_thr1 = aligned & (idx == `ACS_IDX_THR1);
  assign hit_pasel = aligned & (idx == `ACS_IDX_PASEL);
  assign hit_hecx = aligned & (idx == `ACS_IDX_HECX);
  assign hit_urte = aligned & (idx == `ACS_IDX_URTE);
  assign hit_orte = aligned & (idx == `ACS_IDX_ORTE);
  assign hit_stat = aligned & (idx == `ACS_IDX_STAT);
  assign mapped = hit_thr0 | hit_thr1 | hit_pasel | hit_hecx | hit_urte |
                  hit_orte | hit_stat;
  // ready is raised one cycle into the access phase, so the transfer
  // completes at the edge that samples it
  assign acc_done = i_psel & i_penable & o_pready;
  assign wr_done = acc_done & i_pwrite & mapped;

  // ==========================================
  // status word
  reg blk_rx;
  reg blk_a;
  reg blk_b;
  reg blk_c;
  reg [4:0] last_addr;
  wire [`ACS_DATA_W-1:0] stat_word;

  assign stat_word = {19'h00000, last_addr, 2'h0, o_port_a_respond,
                      o_tx_seg_block, blk_c, blk_b, blk_a, blk_rx};

  reg [`ACS_DATA_W-1:0] rd_mux;
  always @* begin
    rd_mux = `ACS_ZERO32;
    if (hit_thr0) begin
      rd_mux = {18'h00000, thr0};
    end else if (hit_thr1) begin
      rd_mux = {28'h0000000, first_unused_thr1};
    end else if (hit_pasel) begin
      rd_mux = {27'h0000000, port_a_sel};
    end else if (hit_hecx) begin
      rd_mux = {24'h000000, hec_xor};
    end else if (hit_urte) begin
      rd_mux = {20'h00000, user_route};
    end else if (hit_orte) begin
      rd_mux = {20'h00000, maint_route};
    end else if (hit_stat) begin
      rd_mux = stat_word;
    end
  end

  // ==========================================
  // apb handshake
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_pready <= 1'b0;
      o_prdata <= `ACS_ZERO32;
      o_pslverr <= 1'b0;
    end else if (i_psel & i_penable & ~o_pready) begin
      o_pready <= 1'b1;
      o_prdata <= i_pwrite ? `ACS_ZERO32 : rd_mux;
      o_pslverr <= ~mapped;
    end else begin
      o_pready <= 1'b0;
      o_prdata <= `ACS_ZERO32;
      o_pslverr <= 1'b0;
    end
  end

  // ==========================================
  // register writes; reserved bits are not stored and read as zero
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      thr0 <= `ACS_THR0_RST;
      first_unused_thr1 <= `ACS_THR1_RST;
      port_a_sel <= `ACS_PASEL_RST;
      hec_xor <= `ACS_HECX_RST;
      user_route <= `ACS_RTE_RST;
      maint_route <= `ACS_RTE_RST;
    end else if (wr_done) begin
      if (hit_thr0) begin
        thr0 <= i_pwdata[`ACS_THR0_W-1:0];
      end
      if (hit_thr1) begin
        first_unused_thr1 <= i_pwdata[`ACS_THR1_W-1:0];
      end
      if (hit_pasel) begin
        port_a_sel <= i_pwdata[`ACS_PASEL_W-1:0];
      end
      if (hit_hecx) begin
        hec_xor <= i_pwdata[`ACS_HECX_W-1:0];
      end
      if (hit_urte) begin
        user_route <= i_pwdata[`ACS_RTE_W-1:0];
      end
      if (hit_orte) begin
        maint_route <= i_pwdata[`ACS_RTE_W-1:0];
      end
    end
  end

  // ==========================================
  // segmenter backpressure
  wire next_blk_rx;
  wire next_blk_a;
  wire next_blk_b;
  wire next_blk_c;

  assign next_blk_rx = (rx_level != `ACS_RX_OFF) & (i_rx_reasm_fill > rx_level);
  assign next_blk_a = (first_port_fifo_block_level != `ACS_PORT_OFF) &
                      (i_port_a_fill > first_port_fifo_block_level);
  assign next_blk_b = (second_port_fifo_block_level != `ACS_PORT_OFF) &
                      (i_port_b_fill > second_port_fifo_block_level);
  assign next_blk_c = (third_port_fifo_block_level != `ACS_PORT_OFF) &
                      (i_port_c_fill > third_port_fifo_block_level);

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      blk_rx <= 1'b0;
      blk_a <= 1'b0;
      blk_b <= 1'b0;
      blk_c <= 1'b0;
      o_tx_seg_block <= 1'b0;
    end else begin
      blk_rx <= next_blk_rx;
      blk_a <= next_blk_a;
      blk_b <= next_blk_b;
      blk_c <= next_blk_c;
      o_tx_seg_block <= next_blk_rx | next_blk_a | next_blk_b | next_blk_c;
    end
  end

  // ==========================================
  // utopia pins: two-stage synchronisers, then rising edge of the link clock
  reg uclk_m;
  reg uclk_s;
  reg uclk_d;
  reg [4:0] uaddr_m;
  reg [4:0] uaddr_s;

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      uclk_m <= 1'b0;
      uclk_s <= 1'b0;
      uclk_d <= 1'b0;
      uaddr_m <= `ACS_UADDR_RST;
      uaddr_s <= `ACS_UADDR_RST;
    end else begin
      uclk_m <= i_utopia_clk;
      uclk_s <= uclk_m;
      uclk_d <= uclk_s;
      uaddr_m <= i_utopia_addr;
      uaddr_s <= uaddr_m;
    end
  end

  wire uclk_rise;
  assign uclk_rise = uclk_s & ~uclk_d;

  // address is taken at each sampled rising edge of the link clock
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_port_a_respond <= 1'b0;
      last_addr <= `ACS_UADDR_RST;
    end else if (uclk_rise) begin
      o_port_a_respond <= (uaddr_s == port_a_sel);
      last_addr <= uaddr_s;
    end
  end

  // ==========================================
  // header check byte masking
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_hec_valid <= 1'b0;
      o_hec_tx <= `ACS_HEC_TX_RST;
    end else begin
      o_hec_valid <= i_hec_valid;
      if (i_hec_valid) begin
        o_hec_tx <= i_hec_calc ^ hec_xor;
      end
    end
  end

  // ==========================================
  // unmatched cell routing
  acs_route u_route (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_cell_valid(i_cell_valid),
    .i_cell_src(i_cell_src),
    .i_cell_oam(i_cell_oam),
    .i_user_route(user_route),
    .i_maint_route(maint_route),
    .o_dest(o_cell_dest),
    .o_dest_valid(o_cell_dest_valid),
    .o_discard(o_cell_discard)
  );

endmodule // acs_switch
`default_nettype wire

// *** acs_switch_chk.sv ***
// acs_switch_chk.sv: port assertions of the cell switch
// assumes: bound into acs_switch, one clock, synchronous reset
`default_nettype none
module acs_switch_chk (
  input wire logic i_ref_clk, // clock
  input wire logic i_reset, // reset
  input wire logic o_pready, // ready
  input wire logic o_pslverr, // error
  input wire logic [5:0] i_rx_reasm_fill, // rx fill
  input wire logic [3:0] i_port_a_fill, // A fill
  input wire logic [3:0] i_port_b_fill, // B fill
  input wire logic [3:0] i_port_c_fill, // C fill
  input wire logic o_tx_seg_block, // blocked
  input wire logic i_hec_valid, // byte in
  input wire logic o_hec_valid, // byte out
  input wire logic [7:0] o_hec_tx, // masked byte
  input wire logic i_cell_valid, // cell in
  input wire logic [3:0] o_cell_dest, // copies
  input wire logic o_cell_dest_valid, // sent
  input wire logic o_cell_discard // dropped
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // properties
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  wire no_fill = {i_rx_reasm_fill, i_port_a_fill, i_port_b_fill, i_port_c_fill} == 18'h00000;
  a_idle_no_block: assert property ($past(no_fill) |-> !o_tx_seg_block)
    else $error("blocked with empty fifos");
  a_hec_pulse: assert property (i_hec_valid |=> o_hec_valid)
    else $error("masked byte missing");
  a_hec_quiet: assert property (!i_hec_valid |=> !o_hec_valid)
    else $error("masked byte unasked");
  a_hec_held: assert property (!o_hec_valid |-> $stable(o_hec_tx))
    else $error("masked byte moved");
  a_route_answer: assert property (i_cell_valid |=> o_cell_dest_valid ^ o_cell_discard)
    else $error("cell not answered once");
  a_route_quiet: assert property (!i_cell_valid |=> !o_cell_dest_valid && !o_cell_discard)
    else $error("route without cell");
  a_dest_nonzero: assert property (o_cell_dest_valid |-> o_cell_dest != 4'h0)
    else $error("forward with empty mask");
  a_apb_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready held");
  c_discard: cover property (i_cell_valid ##1 o_cell_discard);
  c_block: cover property ($rose(o_tx_seg_block));
  c_error: cover property (o_pslverr);
endmodule // acs_switch_chk
bind acs_switch acs_switch_chk u_acs_switch_chk (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_rx_reasm_fill(i_rx_reasm_fill),
  .i_port_a_fill(i_port_a_fill), .i_port_b_fill(i_port_b_fill), .i_port_c_fill(i_port_c_fill),
  .o_tx_seg_block(o_tx_seg_block), .i_hec_valid(i_hec_valid), .o_hec_valid(o_hec_valid),
  .o_hec_tx(o_hec_tx), .i_cell_valid(i_cell_valid), .o_cell_dest(o_cell_dest),
  .o_cell_dest_valid(o_cell_dest_valid), .o_cell_discard(o_cell_discard));
`default_nettype wire

// *** acs_phy_side.sv ***
// acs_phy_side.sv: layer device polling the port A phy address
// assumes: the bench calls poll, link clock period 200 ns
`default_nettype none
module acs_phy_side (
  output logic o_utopia_clk, // link clock, low between polls
  output logic [4:0] o_utopia_addr // polled address
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_utopia_clk = 1'b0;
    o_utopia_addr = 5'h00;
  end
  // address stands 100 ns around the rise, then is turned over
  task automatic poll(input logic [4:0] a);
    o_utopia_addr = a;
    #100 o_utopia_clk = 1'b1;
    #100 o_utopia_clk = 1'b0;
    o_utopia_addr = ~a;
  endtask
endmodule // acs_phy_side
`default_nettype wire

// *** testbench.sv ***
// testbench.sv: cell switch against a behavioural model
// assumes: acs_switch, acs_phy_side and the checker compiled first
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, hv = 1'b0, cv = 1'b0, co = 1'b0;
  logic [12:0] paddr = 13'h0000;
  logic [31:0] pwdata = 32'h00000000, prdata, rdv;
  logic [5:0] rxf = 6'h00;
  logic [3:0] af = 4'h0, bf = 4'h0, cf = 4'h0, dst;
  logic [7:0] hc = 8'h00, ohx;
  logic [1:0] cs = 2'h0;
  logic [4:0] uaddr, sel;
  logic pready, pslverr, blk, uclk, resp, ohv, dv, dd, er;
  logic [12:0] ra [6] = '{13'h1A60, 13'h1A68, 13'h1A80, 13'h1A88, 13'h1A90, 13'h1A98};
  int rm [6] = '{16'h3FFF, 4'hF, 8'h1F, 8'hFF, 12'hFFF, 12'hFFF};
  int rv [6] = '{16'h3F3F, 0, 0, 8'h55, 0, 0};
  int n_mismatch = 0, checked = 0, cyc = 0, seed = 23748;
  int eb, ehv, ed, edv, edd, eht = 0;
  logic [4:0] pa [5];

  always #12.5 i_ref_clk = ~i_ref_clk;

  acs_switch u_acs_switch (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_rx_reasm_fill(rxf), .i_port_a_fill(af),
    .i_port_b_fill(bf), .i_port_c_fill(cf), .o_tx_seg_block(blk), .i_utopia_clk(uclk),
    .i_utopia_addr(uaddr), .o_port_a_respond(resp), .i_hec_valid(hv), .i_hec_calc(hc),
    .o_hec_valid(ohv), .o_hec_tx(ohx), .i_cell_valid(cv), .i_cell_src(cs), .i_cell_oam(co),
    .o_cell_dest(dst), .o_cell_dest_valid(dv), .o_cell_discard(dd));
  acs_phy_side u_acs_phy_side (.o_utopia_clk(uclk), .o_utopia_addr(uaddr));

  // ==========================================
  // tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, s, x);
    end
  endtask

  task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    pen <= 1'b1;
    // ready, read data and error are taken at the edge that completes the access
    do begin
      @(posedge i_ref_clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input int k, input int d);
    apb(1'b1, ra[k], d & rm[k]);
    rv[k] = d & rm[k];
  endtask

  function automatic int over(int f, int lv, int off);
    return lv != off && f > lv;
  endfunction

  task summarize();
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ==========================================
  // scenarios
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, ra[k], 32'h00000000);
      chk(rdv, rv[k]);
    end
    apb(1'b1, 13'h1AB0, 32'hFFFFFFFF);
    chk(er, 1'b1);
    for (int k = 0; k < 6; k++) begin
      wr(k, $random(seed));
      apb(1'b0, ra[k], 32'h00000000);
      chk(rdv, rv[k]);
    end
    for (int c = 0; c < 4; c++) begin
      wr(0, c == 3 ? 32'hFFFFFFFF : $random(seed));
      wr(1, c == 3 ? 32'hFFFFFFFF : $random(seed));
      repeat (40) begin
        @(posedge i_ref_clk);
        {rxf, af, bf, cf} <= 18'($random(seed));
        @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        eb = over(rxf, rv[0] & 63, 63) || over(af, rv[0] >> 6 & 15, 15);
        eb = eb || over(bf, rv[0] >> 10 & 15, 15) || over(cf, rv[1], 15);
        chk(blk, eb);
      end
    end
    // back to back check bytes and unmatched cells
    for (int i = 0; i < 61; i++) begin
      @(posedge i_ref_clk);
      {hv, cv, co, cs, hc} <= i < 60 ? 13'($random(seed)) : 13'h0000;
      @(negedge i_ref_clk);
      if (i > 0) begin
        chk(ohv, ehv);
        chk(ohx, eht);
        chk(dst, ed);
        chk(dv, edv);
        chk(dd, edd);
      end
      ehv = hv;
      if (hv) eht = hc ^ rv[3];
      ed = cv && cs != 2'h3 ? (co ? rv[5] : rv[4]) >> 4 * cs & 15 : 0;
      edv = cv && ed != 0;
      edd = cv && ed == 0;
    end
    wr(2, $random(seed));
    sel = 5'(rv[2]);
    pa = '{sel, sel ^ 5'h01, sel ^ 5'h10, ~sel, sel};
    @(negedge i_ref_clk);
    foreach (pa[j]) begin
      u_acs_phy_side.poll(pa[j]);
      repeat (3) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      chk(resp, pa[j] == sel);
    end
    // status word: last polled address, port A answering, no block with levels off
    apb(1'b0, 13'h1AA0, 32'h00000000);
    chk(rdv, {19'h00000, sel, 8'h20});
    summarize();
  end
endmodule // testbench
`default_nettype wire
